// ---- hw/ctu_pkg.sv ----
package ctu_pkg;
    // register map, word index on the plain register port
    localparam logic [1:0] ADDR_CURRENT = 2'h0;
    localparam logic [1:0] ADDR_EDGE_LOW = 2'h1;
    localparam logic [1:0] ADDR_UNIT_HIGH = 2'h2;
    localparam logic [1:0] ADDR_IRQ = 2'h3;
    // current_source_control fields
    localparam int RANGE_LSB = 0;
    localparam int TRIM_LSB = 2;
    localparam logic [7:0] CURRENT_RESET = 8'h00;
    // edge_control_low fields
    localparam int SEEN1_BIT = 0;
    localparam int SEEN2_BIT = 1;
    localparam int SRC1_LSB = 2;
    localparam int POL1_BIT = 4;
    localparam int SRC2_LSB = 5;
    localparam int POL2_BIT = 7;
    localparam logic [7:0] EDGE_LOW_RESET = 8'h00;
    // unit_control_high fields
    localparam int DISCHARGE_BIT = 1;
    localparam int ORDER_BIT = 2;
    localparam int EDGE_EN_BIT = 3;
    localparam int DELAY_MODE_BIT = 4;
    localparam int UNIT_EN_BIT = 7;
    localparam logic [7:0] UNIT_HIGH_RESET = 8'h00;
    // flag and enable byte: flag at bit 2, enable at bit 2 of upper nibble view
    localparam int IRQ_FLAG_BIT = 2;
    localparam int IRQ_EN_BIT = 6;
    // edge sources
    typedef enum logic [1:0] {
        SRC_PIN_A = 2'h0,
        SRC_PIN_B = 2'h1,
        SRC_TIMER1 = 2'h2,
        SRC_COMPARE1 = 2'h3
    } ctu_src_t;
    typedef struct packed {
        logic pin_a;
        logic pin_b;
        logic timer1;
        logic compare1;
    } ctu_sources_t;
    typedef struct packed {
        logic [1:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } ctu_bus_t;
endpackage : ctu_pkg

// ---- hw/ctu_edge_control.sv ----
// Design decisions made here: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
// How it works
// RULE1: range field sits in bits 1:0 of current control; 01 is lowest.
// RULE2: six-bit signed trim in bits 7:2, zero is neutral.
// RULE3: each edge channel picks pin a, pin b, timer1 or compare1.
// RULE4: channels react to the present level, not to transitions.
// RULE5: per-channel polarity at bits 7 and 4 of the low control.
// RULE6: with ordering on, edge 2 counts only after edge 1.
// RULE7: status bits 1:0 set by hardware on a channel event.
// RULE8: config change matching the present level sets status at once.
// RULE9: current on only while exactly one status bit is set.
// RULE10: software clears both status bits together between measurements.
// RULE11: software may write status bits to switch current directly.
// RULE12: flag sets each time current goes from on to off.
// RULE13: interrupt requested only when flag and enable are both set.
// RULE14: without ordering, software reads status to see the last edge.
// RULE15: mode bit 4 of high control picks delay mode; reset is measure.
// RULE16: reset polarity is low level, ordering disabled.
// RULE17: discharge bit 1 of high control drains the circuit while set.
// RULE18: unit enable bit 7 of high control turns the unit on.
// RULE19: edge enable bit 3 gates both edge inputs.
// RULE20: software follows the documented setup order.
// RULE21: delay mode ends the pulse with comparator 2.
// RULE22: polarity one means high level, zero means low level.
// RULE23: hardware sets status only with unit and edge enables set; a comparator 2 trip in delay mode also sets both bits with edge enable clear.
// RULE24: selected edge levels are synchronised before use.
module ctu_edge_control (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // register port
    input wire ctu_pkg::ctu_bus_t bus,
    output logic [7:0] rdata,
    // edge sources, asynchronous
    input wire ctu_pkg::ctu_sources_t sources,
    // comparator 2 output, asynchronous
    input wire logic comparator2,
    // analog controls and interrupt request
    output logic current_on,
    output logic [1:0] current_range_sel,
    output logic [5:0] current_trim,
    output logic discharge_enable,
    output logic delay_mode_select,
    output logic unit_enable,
    output logic irq
);
    logic [7:0] current_source_control;
    logic [7:0] edge_control_low;
    logic [7:0] unit_control_high;
    logic irq_flag;
    logic irq_en;
    ctu_pkg::ctu_sources_t src_meta;
    ctu_pkg::ctu_sources_t src_sync;
    logic cmp_meta;
    logic cmp_sync;
    logic [1:0] hit;
    logic [1:0] next_seen;
    logic next_on;
    logic wr_cur;
    logic wr_low;
    logic wr_high;
    logic wr_irq;
    logic [7:0] low_view;
    logic hw_ok;

    function automatic logic pick(input ctu_pkg::ctu_sources_t s, input logic [1:0] sel);
        case (sel)
            2'h0: pick = s.pin_a;
            2'h1: pick = s.pin_b;
            2'h2: pick = s.timer1;
            default: pick = s.compare1;
        endcase
    endfunction : pick

    assign wr_cur = bus.wr && bus.addr == ctu_pkg::ADDR_CURRENT;
    assign wr_low = bus.wr && bus.addr == ctu_pkg::ADDR_EDGE_LOW;
    assign wr_high = bus.wr && bus.addr == ctu_pkg::ADDR_UNIT_HIGH;
    assign wr_irq = bus.wr && bus.addr == ctu_pkg::ADDR_IRQ;

    // two stages per source; nothing reads the first stage but the second
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            src_meta <= '0;
            src_sync <= '0;
            cmp_meta <= 1'b0;
            cmp_sync <= 1'b0;
        end else begin
            src_meta <= sources; // [RULE24]
            src_sync <= src_meta; // [RULE24]
            cmp_meta <= comparator2;
            cmp_sync <= cmp_meta;
        end
    end

    // the config used is the value about to be written, so a write that matches
    // the present level sets the status bit in the same cycle
    always_comb begin
        low_view = wr_low ? bus.wdata : edge_control_low;
        hw_ok = unit_control_high[ctu_pkg::UNIT_EN_BIT]
            && unit_control_high[ctu_pkg::EDGE_EN_BIT]; // [RULE18] [RULE19] [RULE23]
        hit[0] = hw_ok && (pick(src_sync, low_view[ctu_pkg::SRC1_LSB +: 2])
            == low_view[ctu_pkg::POL1_BIT]); // [RULE3] [RULE4] [RULE5] [RULE8] [RULE22]
        hit[1] = hw_ok && (pick(src_sync, low_view[ctu_pkg::SRC2_LSB +: 2])
            == low_view[ctu_pkg::POL2_BIT]); // [RULE3] [RULE4] [RULE5] [RULE8] [RULE22]
        // ordering: edge 2 waits for edge 1 already set
        if (unit_control_high[ctu_pkg::ORDER_BIT] && !edge_control_low[ctu_pkg::SEEN1_BIT]) begin
            hit[1] = 1'b0; // [RULE6]
        end
        next_seen = wr_low ? bus.wdata[1:0] : edge_control_low[1:0]; // [RULE11]
        next_seen = next_seen | hit; // [RULE7]
        // delay mode: comparator 2 trip acts as the ending edge
        if (unit_control_high[ctu_pkg::DELAY_MODE_BIT] && unit_control_high[ctu_pkg::UNIT_EN_BIT]
            && cmp_sync && next_seen != 2'h0) begin
            next_seen = 2'h3; // [RULE21]
        end
        // current also needs the unit on, so a disabled unit never drives the pin
        next_on = unit_control_high[ctu_pkg::UNIT_EN_BIT]
            && (next_seen[0] ^ next_seen[1]); // [RULE9]
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            current_source_control <= ctu_pkg::CURRENT_RESET;
        end else if (wr_cur) begin
            current_source_control <= bus.wdata; // [RULE1] [RULE2]
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            edge_control_low <= ctu_pkg::EDGE_LOW_RESET; // [RULE16]
        end else begin
            edge_control_low <= {low_view[7:2], next_seen}; // [RULE7] [RULE11]
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            unit_control_high <= ctu_pkg::UNIT_HIGH_RESET; // [RULE15] [RULE16]
        end else if (wr_high) begin
            unit_control_high <= bus.wdata;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            current_on <= 1'b0;
        end else begin
            current_on <= next_on; // [RULE9]
        end
    end

    // set on the falling current wins over a software clear in the same cycle
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_flag <= 1'b0;
            irq_en <= 1'b0;
        end else begin
            if (current_on && !next_on) begin
                irq_flag <= 1'b1; // [RULE12]
            end else if (wr_irq) begin
                irq_flag <= bus.wdata[ctu_pkg::IRQ_FLAG_BIT];
            end
            if (wr_irq) begin
                irq_en <= bus.wdata[ctu_pkg::IRQ_EN_BIT];
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq <= 1'b0;
        end else begin
            irq <= (irq_flag || (current_on && !next_on)) && irq_en; // [RULE13]
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            current_range_sel <= 2'h0;
            current_trim <= 6'h00;
            discharge_enable <= 1'b0;
            delay_mode_select <= 1'b0;
            unit_enable <= 1'b0;
        end else begin
            current_range_sel <= current_source_control[ctu_pkg::RANGE_LSB +: 2]; // [RULE1]
            current_trim <= current_source_control[ctu_pkg::TRIM_LSB +: 6]; // [RULE2]
            discharge_enable <= unit_control_high[ctu_pkg::DISCHARGE_BIT]; // [RULE17]
            delay_mode_select <= unit_control_high[ctu_pkg::DELAY_MODE_BIT]; // [RULE15]
            unit_enable <= unit_control_high[ctu_pkg::UNIT_EN_BIT]; // [RULE18]
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= 8'h00;
        end else if (bus.rd) begin
            case (bus.addr)
                ctu_pkg::ADDR_CURRENT: rdata <= current_source_control;
                ctu_pkg::ADDR_EDGE_LOW: rdata <= edge_control_low;
                ctu_pkg::ADDR_UNIT_HIGH: rdata <= unit_control_high;
                ctu_pkg::ADDR_IRQ: rdata <= {1'b0, irq_en, 3'h0, irq_flag, 2'h0};
                default: rdata <= 8'h00;
            endcase
        end else begin
            rdata <= 8'h00;
        end
    end

    // status pair and current_on are updated on the same edge
    AST_ON_EXACT_ONE: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE9]
        current_on
        |-> (edge_control_low[ctu_pkg::SEEN1_BIT] ^ edge_control_low[ctu_pkg::SEEN2_BIT]))
        else $error("current on without exactly one status bit");

    AST_FLAG_ON_FALL: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE12]
        $fell(current_on) |-> irq_flag)
        else $error("flag not set after current turned off");

    AST_IRQ_GATED: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE13]
        irq |-> $past(irq_en))
        else $error("interrupt without enable");

    AST_ORDER: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE6]
        (!wr_low && edge_control_low[1:0] == 2'h0 && unit_control_high[ctu_pkg::ORDER_BIT])
        |=> !(edge_control_low[ctu_pkg::SEEN2_BIT] && !edge_control_low[ctu_pkg::SEEN1_BIT]))
        else $error("edge 2 accepted before edge 1");

    AST_NO_HW_SET: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE19] [RULE23]
        (!wr_low && !unit_control_high[ctu_pkg::EDGE_EN_BIT]
            && !unit_control_high[ctu_pkg::DELAY_MODE_BIT] && edge_control_low[1:0] == 2'h0)
        |=> edge_control_low[1:0] == 2'h0)
        else $error("status set while edges disabled");

    AST_SW_WRITE: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE11]
        (wr_low && !hw_ok && !unit_control_high[ctu_pkg::DELAY_MODE_BIT])
        |=> edge_control_low[1:0] == $past(bus.wdata[1:0]))
        else $error("status write not taken");

    AST_LEVEL_SET: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE4] [RULE7]
        (hw_ok && !wr_low && src_sync.pin_a == edge_control_low[ctu_pkg::POL1_BIT]
            && edge_control_low[ctu_pkg::SRC1_LSB +: 2] == 2'h0)
        |=> edge_control_low[ctu_pkg::SEEN1_BIT])
        else $error("matching level did not set edge 1");

    // a second write right behind the first would move the output again
    AST_RANGE_OUT: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE1]
        (wr_cur ##1 !wr_cur) |=> current_range_sel == $past(bus.wdata[1:0], 2))
        else $error("range output does not follow register");

    AST_TRIM_OUT: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE2]
        (wr_cur ##1 !wr_cur) |=> current_trim == $past(bus.wdata[7:2], 2))
        else $error("trim output does not follow register");

    AST_CTRL_OUT: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE15] [RULE17] [RULE18]
        {discharge_enable, delay_mode_select, unit_enable}
        == {$past(unit_control_high[ctu_pkg::DISCHARGE_BIT]),
            $past(unit_control_high[ctu_pkg::DELAY_MODE_BIT]),
            $past(unit_control_high[ctu_pkg::UNIT_EN_BIT])})
        else $error("control outputs do not follow register");

    AST_OFF_NO_UNIT: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE9] [RULE18]
        !unit_control_high[ctu_pkg::UNIT_EN_BIT] |=> !current_on)
        else $error("current on while unit disabled");

    AST_ON_ONE_SET: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE9] [RULE11]
        (unit_control_high[ctu_pkg::UNIT_EN_BIT] && !wr_low && !hw_ok
            && !unit_control_high[ctu_pkg::DELAY_MODE_BIT]
            && (edge_control_low[ctu_pkg::SEEN1_BIT] ^ edge_control_low[ctu_pkg::SEEN2_BIT]))
        |=> current_on)
        else $error("current off with exactly one status bit");

    // hardware only ever sets status; clearing is left to software
    AST_SEEN_STICKY: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE7]
        !wr_low
        |=> (edge_control_low[1:0] & $past(edge_control_low[1:0])) == $past(edge_control_low[1:0]))
        else $error("status bit cleared by hardware");

    AST_CFG_KEEP: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE3] [RULE5]
        !wr_low |=> $stable(edge_control_low[7:2]))
        else $error("edge config changed without a write");

    AST_CFG_WRITE: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE3] [RULE5]
        wr_low |=> edge_control_low[7:2] == $past(bus.wdata[7:2]))
        else $error("edge config write not taken");

    AST_WRITE_MATCH: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE8]
        (wr_low && hw_ok && bus.wdata[ctu_pkg::SRC1_LSB +: 2] == 2'h0
            && src_sync.pin_a == bus.wdata[ctu_pkg::POL1_BIT])
        |=> edge_control_low[ctu_pkg::SEEN1_BIT])
        else $error("matching config write did not set edge 1");

    AST_POL_HIGH: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE5] [RULE22]
        (hw_ok && !wr_low && !unit_control_high[ctu_pkg::ORDER_BIT]
            && edge_control_low[ctu_pkg::SRC2_LSB +: 2] == 2'h0
            && edge_control_low[ctu_pkg::POL2_BIT] && src_sync.pin_a)
        |=> edge_control_low[ctu_pkg::SEEN2_BIT])
        else $error("high level did not set edge 2");

    AST_ORDER_OFF: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE6] [RULE22]
        (hw_ok && !wr_low && !unit_control_high[ctu_pkg::ORDER_BIT]
            && edge_control_low[ctu_pkg::SRC2_LSB +: 2] == 2'h0
            && !edge_control_low[ctu_pkg::POL2_BIT] && !src_sync.pin_a)
        |=> edge_control_low[ctu_pkg::SEEN2_BIT])
        else $error("low level did not set edge 2 without ordering");

    AST_DELAY_END: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE21]
        (unit_control_high[ctu_pkg::UNIT_EN_BIT] && unit_control_high[ctu_pkg::DELAY_MODE_BIT]
            && cmp_sync && !wr_low && edge_control_low[1:0] != 2'h0)
        |=> edge_control_low[1:0] == 2'h3)
        else $error("comparator trip did not end the pulse");

    AST_IRQ_QUIET: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE13]
        (!irq_flag && !(current_on && !next_on)) |=> !irq)
        else $error("interrupt without flag");

    AST_IRQ_RAISE: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE13]
        (irq_flag && irq_en) |=> irq)
        else $error("flag and enable set but no interrupt");

    AST_FLAG_CLEAR: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE12]
        (wr_irq && !bus.wdata[ctu_pkg::IRQ_FLAG_BIT] && !(current_on && !next_on))
        |=> !irq_flag)
        else $error("flag clear not taken");

    AST_FLAG_HOLD: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE12]
        (irq_flag && !wr_irq) |=> irq_flag)
        else $error("flag lost without a write");

    AST_EN_WRITE: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE13]
        wr_irq |=> irq_en == $past(bus.wdata[ctu_pkg::IRQ_EN_BIT]))
        else $error("interrupt enable write not taken");

    AST_CUR_WRITE: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE1] [RULE2]
        wr_cur |=> current_source_control == $past(bus.wdata))
        else $error("current control write not taken");

    AST_CUR_HOLD: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE1] [RULE2]
        !wr_cur |=> $stable(current_source_control))
        else $error("current control changed without a write");

    AST_HIGH_WRITE: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE15]
        wr_high |=> unit_control_high == $past(bus.wdata))
        else $error("unit control write not taken");

    AST_HIGH_HOLD: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE15]
        !wr_high |=> $stable(unit_control_high))
        else $error("unit control changed without a write");

    // read data stand for one cycle only, zero otherwise
    AST_RDATA_IDLE: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !bus.rd |=> rdata == 8'h00)
        else $error("read data without a read");

    AST_RDATA_CUR: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (bus.rd && bus.addr == ctu_pkg::ADDR_CURRENT)
        |=> rdata == $past(current_source_control))
        else $error("wrong current control read data");

    AST_RDATA_LOW: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (bus.rd && bus.addr == ctu_pkg::ADDR_EDGE_LOW)
        |=> rdata == $past(edge_control_low))
        else $error("wrong edge control read data");

    AST_RDATA_HIGH: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (bus.rd && bus.addr == ctu_pkg::ADDR_UNIT_HIGH)
        |=> rdata == $past(unit_control_high))
        else $error("wrong unit control read data");

    AST_RDATA_IRQ: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE12] [RULE13]
        (bus.rd && bus.addr == ctu_pkg::ADDR_IRQ)
        |=> rdata == {1'b0, $past(irq_en), 3'h0, $past(irq_flag), 2'h0})
        else $error("wrong flag and enable read data");
endmodule : ctu_edge_control

// ---- tb/ctu_edge_src_model.sv ----
`timescale 1ns/1ps
module ctu_edge_src_model (
    // commanded levels
    input wire logic [3:0] lvl,
    input wire logic cmp_lvl,
    input wire logic slow,
    // levels seen by the unit
    output ctu_pkg::ctu_sources_t sources,
    output logic comparator2
);
    initial sources = '0;
    initial comparator2 = 1'b0;
    // sources are held as levels, settling after a lag unrelated to the unit clock
    always @(lvl) sources <= #(slow ? 137 : 3) lvl;
    always @(cmp_lvl) comparator2 <= #(slow ? 91 : 5) cmp_lvl;
endmodule : ctu_edge_src_model

// ---- tb/charge_time_edge_control_tb.sv ----
`timescale 1ns/1ps
module charge_time_edge_control_tb;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    ctu_pkg::ctu_bus_t bus = '0;
    ctu_pkg::ctu_sources_t sources;
    logic [7:0] rdata, rd_val, cfg;
    logic [3:0] lvl = 4'h0;
    logic cmp_lvl = 1'b0;
    logic slow = 1'b0;
    logic comparator2, current_on, discharge_enable, delay_mode_select, unit_enable, irq;
    logic [1:0] current_range_sel;
    logic [5:0] current_trim;
    integer seed = 32'hcf273ba4;
    int err_total = 0;
    int num_checks = 0;
    always #25 ref_clk = ~ref_clk;
    ctu_edge_control dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .bus(bus), .rdata(rdata),
        .sources(sources), .comparator2(comparator2), .current_on(current_on),
        .current_range_sel(current_range_sel), .current_trim(current_trim),
        .discharge_enable(discharge_enable), .delay_mode_select(delay_mode_select),
        .unit_enable(unit_enable), .irq(irq));
    ctu_edge_src_model src_u (.lvl(lvl), .cmp_lvl(cmp_lvl), .slow(slow),
        .sources(sources), .comparator2(comparator2));
    task automatic print_verdict();
        if (err_total == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : print_verdict
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge ref_clk);
        bus <= '0;
    endtask : wr
    task automatic rd(input logic [1:0] a);
        @(posedge ref_clk);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge ref_clk);
        bus <= '0;
        #1 rd_val = rdata;
    endtask : rd
    task automatic drive(input logic [3:0] v);
        @(posedge ref_clk);
        lvl <= v;
    endtask : drive
    // polls the status pair; a poll that never matches ends the run
    task automatic wait_seen(input logic [1:0] want);
        for (int i = 0; i < 12; i++) begin
            rd(ctu_pkg::ADDR_EDGE_LOW);
            if (rd_val[1:0] === want) return;
        end
        chk("status wait", {6'h0, want}, rd_val);
        print_verdict();
    endtask : wait_seen
    // selected source at the wanted level, the other three random
    function automatic logic [3:0] levels(input int s, input logic act);
        logic [3:0] r;
        r = 4'($random(seed));
        r[3 - s] = act;
        return r;
    endfunction : levels
    initial begin
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        for (int a = 0; a < 4; a++) begin
            rd(a[1:0]);
            chk("reset reg", 8'h00, rd_val);
        end
        for (int i = 0; i < 6; i++) begin
            cfg = (i == 0) ? 8'h01 : (i == 1) ? 8'h85 : (i == 2) ? 8'h7d : 8'($random(seed));
            wr(ctu_pkg::ADDR_CURRENT, cfg);
            rd(ctu_pkg::ADDR_CURRENT);
            chk("range", {6'h0, cfg[1:0]}, {6'h0, current_range_sel});
            chk("trim", {2'h0, cfg[7:2]}, {2'h0, current_trim});
        end
        wr(ctu_pkg::ADDR_UNIT_HIGH, 8'h80);
        wr(ctu_pkg::ADDR_IRQ, 8'h40);
        for (int i = 0; i < 4; i++) begin
            wr(ctu_pkg::ADDR_EDGE_LOW, 8'(i));
            rd(ctu_pkg::ADDR_IRQ);
            chk("sw current", {7'h0, i == 1 || i == 2}, {7'h0, current_on});
        end
        rd(ctu_pkg::ADDR_IRQ);
        chk("flag", 8'h44, rd_val);
        chk("irq", 8'h01, {7'h0, irq});
        wr(ctu_pkg::ADDR_EDGE_LOW, 8'h00);
        wr(ctu_pkg::ADDR_IRQ, 8'h00);
        wr(ctu_pkg::ADDR_EDGE_LOW, 8'h01);
        wr(ctu_pkg::ADDR_EDGE_LOW, 8'h00);
        rd(ctu_pkg::ADDR_IRQ);
        chk("masked irq", 8'h04, {rd_val[7:1], irq});
        wr(ctu_pkg::ADDR_IRQ, 8'h00);
        for (int s = 0; s < 4; s++) begin
            for (int p = 0; p < 2; p++) begin
                slow <= p[0];
                // channel 2 watches the same source with the opposite level
                cfg = {~p[0], s[1:0], p[0], s[1:0], 2'b00};
                wr(ctu_pkg::ADDR_UNIT_HIGH, 8'h84);
                wr(ctu_pkg::ADDR_EDGE_LOW, cfg);
                drive(levels(s, p[0]));
                repeat (8) @(posedge ref_clk);
                rd(ctu_pkg::ADDR_EDGE_LOW);
                chk("gated status", cfg, rd_val);
                drive(levels(s, ~p[0]));
                repeat (8) @(posedge ref_clk);
                wr(ctu_pkg::ADDR_UNIT_HIGH, 8'h8c);
                repeat (8) @(posedge ref_clk);
                rd(ctu_pkg::ADDR_EDGE_LOW);
                chk("ordered status", cfg, rd_val);
                drive(levels(s, p[0]));
                wait_seen(2'b01);
                chk("measuring", 8'h01, {7'h0, current_on});
                drive(levels(s, ~p[0]));
                wait_seen(2'b11);
                rd(ctu_pkg::ADDR_IRQ);
                chk("end flag", 8'h04, rd_val & 8'h04);
                chk("stopped", 8'h00, {7'h0, current_on});
                wr(ctu_pkg::ADDR_IRQ, 8'h00);
            end
        end
        wr(ctu_pkg::ADDR_UNIT_HIGH, 8'h88);
        drive(4'h8);
        repeat (8) @(posedge ref_clk);
        wr(ctu_pkg::ADDR_EDGE_LOW, 8'h00);
        wr(ctu_pkg::ADDR_EDGE_LOW, 8'h10);
        wait_seen(2'b01);
        wr(ctu_pkg::ADDR_UNIT_HIGH, 8'h9a);
        rd(ctu_pkg::ADDR_UNIT_HIGH);
        chk("controls", 8'h07,
        {5'h0, discharge_enable, delay_mode_select, unit_enable});
        @(posedge ref_clk);
        cmp_lvl <= 1'b1;
        wait_seen(2'b11);
        chk("pulse end", 8'h00, {7'h0, current_on});
        print_verdict();
    end
endmodule : charge_time_edge_control_tb
